// [hdl/streamer_regs_pkg.sv]
// Offsets, field positions, reset values and carriers of the streamer status registers
package streamer_regs_pkg;
	localparam int ADDR_W = 16;
	typedef logic [ADDR_W-1:0] reg_addr_t;

	localparam reg_addr_t OFS_ERROR_LOCATION = 16'h4064;
	localparam reg_addr_t OFS_ERROR_HEADER = 16'h4068;
	localparam reg_addr_t OFS_ACTIVE_HEAD = 16'h4074;
	localparam reg_addr_t OFS_FETCH_OFFSET = 16'h4078;
	localparam reg_addr_t OFS_STATUS_PAGE = 16'h4080;
	localparam reg_addr_t OFS_NOOP_ID = 16'h4094;
	localparam reg_addr_t OFS_SW_MODE = 16'h409C;
	localparam reg_addr_t OFS_IDENTITY = 16'h40A4;
	localparam reg_addr_t OFS_ERROR_STATUS = 16'h40B0;
	localparam reg_addr_t OFS_ERROR_MASK = 16'h40B4;
	localparam reg_addr_t OFS_PARSER_MODE = 16'h40C0;
	localparam reg_addr_t OFS_PENDING_HEAD = 16'h4134;
	localparam reg_addr_t OFS_TIMEOUT_COUNT = 16'h4178;
	localparam reg_addr_t OFS_TIMEOUT_THRESH = 16'h417C;

	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RST_STATUS_PAGE = 32'h1FFF_F000;
	localparam logic [31:0] RST_TIMEOUT_COUNT = 32'hFFFF_FFFF;
	localparam logic [31:0] RST_TIMEOUT_THRESH = 32'h0001_4500;
	localparam logic [31:0] COUNT_STOP = 32'hFFFF_FFFF;

	localparam int IRQ_TIMEOUT = 7;
	localparam int IRQ_MASTER_ERR = 2;
	localparam int IRQ_SYNC = 1;
	localparam int IRQ_USER = 0;
	localparam int LOC_BATCH = 3;
	localparam int MODE_INVAL_PENDING = 11;
	localparam int MODE_IDLE = 9;
	localparam int MODE_STOP = 8;
	localparam int PMC_SYNC_FLUSH = 5;
	localparam int ERR_W = 2;
	localparam int ERR_PARSER = 0;
	localparam int ERR_PAGE_TABLE = 1;
	localparam int NOOP_ID_W = 22;
	localparam logic [9:0] DW_SYNC_STATUS = 10'h000;
	localparam logic [9:0] DW_HEAD_REPORT = 10'h004;

	typedef struct packed {
		logic exec_valid;
		logic [31:0] header;
		logic error_valid;
		logic error_from_batch;
		logic page_fault;
		logic user_irq;
		logic noop_update;
		logic [NOOP_ID_W-1:0] noop_id;
		logic report_head;
	} parser_event_t;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [31:0] data;
		logic flush_cache;
	} status_write_t;
endpackage : streamer_regs_pkg

// [hdl/interrupt_identity_bank.sv]
// Sticky and toggling interrupt identity bits of the streamer
module interrupt_identity_bank (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic timeout_hit,
	input wire logic master_err_pending,
	input wire logic sync_done,
	input wire logic user_irq,
	input wire logic clear_wr,
	input wire logic [31:0] clear_data,
	output logic [31:0] identity
);
	import streamer_regs_pkg::*;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			identity <= RST_ZERO;
		end else begin
			// Set beats a simultaneous write-one clear
			if (timeout_hit) begin
				identity[IRQ_TIMEOUT] <= 1'b1;
			end else if (clear_wr && clear_data[IRQ_TIMEOUT]) begin
				identity[IRQ_TIMEOUT] <= 1'b0;
			end
			// Stays up until every unmasked error source is cleared first
			if (master_err_pending) begin
				identity[IRQ_MASTER_ERR] <= 1'b1;
			end else if (clear_wr && clear_data[IRQ_MASTER_ERR]) begin
				identity[IRQ_MASTER_ERR] <= 1'b0;
			end
			if (sync_done) begin
				identity[IRQ_SYNC] <= ~identity[IRQ_SYNC];
			end
			if (user_irq) begin
				identity[IRQ_USER] <= 1'b1;
			end else if (clear_wr && clear_data[IRQ_USER]) begin
				identity[IRQ_USER] <= 1'b0;
			end
		end
	end
endmodule : interrupt_identity_bank

// [hdl/cmd_streamer_status_regs.sv]
// Status, debug and interrupt identity registers of the decode command streamer
// Function
// - Timeout counter reaching threshold sets identity bit 7.
// - Parser error sets bit 2; cleared after error source cleared, then bit 2 written.
// - Master error only from unmasked reported error conditions.
// - Bit 1 toggles when sync flush finishes after all engines flushed.
// - Sync toggle issues a coherent status dword write with cache flush.
// - User interrupt instruction sets bit 0; execution continues.
// - Location bit 3 shows whether faulting instruction came from batch buffer.
// - Error header loads first dword of every executed instruction.
// - Active head reports dword address in 31:2, low bits zero.
// - Fetch offset reports qword offset in 31:3, leading the head.
// - Status page address uses 31:12, resets to 1FFF F000h.
// - Head report writes ring head into status page dword 4.
// - Noop identifier holds last enabled 22-bit id; upper bits read zero.
// - Mode bits 15:0 change only where mask bit 31:16 is one.
// - With mode bit 11, pending head valid clears when heads match.
// - Stop ring bit 8 halts parser; idle bit 9 read-only.
// - Sync flush request bit 5 self-clears when the flush completes.
module cmd_streamer_status_regs (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire streamer_regs_pkg::reg_addr_t reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rd_valid,
	input wire streamer_regs_pkg::parser_event_t parser_evt,
	input wire logic [31:0] head_addr,
	input wire logic [31:0] fetch_offset,
	input wire logic parser_idle,
	input wire logic engines_flushed,
	input wire logic pending_head_taken,
	output logic stop_ring,
	output logic flush_req,
	output logic [31:0] pending_head,
	output logic pending_head_valid,
	output streamer_regs_pkg::status_write_t status_wr,
	input wire logic status_wr_ready,
	output logic [31:0] interrupt_identity
);
	import streamer_regs_pkg::*;

	typedef enum {SYNC_IDLE, SYNC_FLUSH, SYNC_WRITE} sync_state_t;

	function automatic logic [15:0] masked_update(input logic [15:0] cur, input logic [31:0] wd);
		masked_update = (cur & ~wd[31:16]) | (wd[15:0] & wd[31:16]);
	endfunction : masked_update

	logic [31:0] error_header;
	logic error_from_batch;
	logic [31:0] status_page;
	logic [NOOP_ID_W-1:0] noop_id;
	logic [15:0] sw_mode;
	logic [15:0] parser_mode;
	logic [ERR_W-1:0] error_status;
	logic [ERR_W-1:0] error_mask;
	logic [31:0] timeout_count;
	logic [31:0] timeout_thresh;
	logic [31:0] head_report_value;
	logic head_report_pending;
	logic timeout_hit;
	logic sync_done;
	logic master_err_pending;
	logic out_free;
	logic take_sync;
	logic take_head;
	logic heads_match;
	logic [31:0] next_rdata;
	sync_state_t sync_state;

	// Write strobes per register
	function automatic logic wr_hit(input logic en, input reg_addr_t a, input reg_addr_t ofs);
		wr_hit = en && (a == ofs);
	endfunction : wr_hit

	assign stop_ring = sw_mode[MODE_STOP];
	assign flush_req = (sync_state == SYNC_FLUSH);
	assign master_err_pending = |(error_status & ~error_mask);
	assign out_free = !status_wr.valid || status_wr_ready;
	assign take_sync = out_free && (sync_state == SYNC_WRITE);
	assign take_head = out_free && !take_sync && head_report_pending;
	assign heads_match = (head_addr[31:3] == pending_head[31:3]);

	// Debug captures; no write path reaches them
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			error_header <= RST_ZERO;
		end else if (parser_evt.exec_valid) begin
			error_header <= parser_evt.header;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			error_from_batch <= 1'b0;
		end else if (parser_evt.error_valid) begin
			error_from_batch <= parser_evt.error_from_batch;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			noop_id <= '0;
		end else if (parser_evt.noop_update) begin
			noop_id <= parser_evt.noop_id;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			status_page <= RST_STATUS_PAGE;
		end else if (wr_hit(reg_wr_en, reg_addr, OFS_STATUS_PAGE)) begin
			status_page <= {reg_wdata[31:12], 12'h000};
		end
	end

	// Error sources: hardware set wins over software write-one clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			error_status <= '0;
		end else begin
			for (int i = 0; i < ERR_W; i++) begin
				if ((i == ERR_PARSER && parser_evt.error_valid) ||
				    (i == ERR_PAGE_TABLE && parser_evt.page_fault)) begin
					error_status[i] <= 1'b1;
				end else if (wr_hit(reg_wr_en, reg_addr, OFS_ERROR_STATUS) && reg_wdata[i]) begin
					error_status[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			error_mask <= '0;
		end else if (wr_hit(reg_wr_en, reg_addr, OFS_ERROR_MASK)) begin
			error_mask <= reg_wdata[ERR_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sw_mode <= RST_ZERO[15:0];
		end else if (wr_hit(reg_wr_en, reg_addr, OFS_SW_MODE)) begin
			sw_mode <= masked_update(sw_mode, reg_wdata);
		end
	end

	// Flush bit self-clears even under an unrelated write, unless that write re-arms it
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			parser_mode <= RST_ZERO[15:0];
		end else begin
			if (wr_hit(reg_wr_en, reg_addr, OFS_PARSER_MODE)) begin
				parser_mode <= masked_update(parser_mode, reg_wdata);
			end
			if (sync_done && !(wr_hit(reg_wr_en, reg_addr, OFS_PARSER_MODE) &&
			    reg_wdata[16 + PMC_SYNC_FLUSH])) begin
				parser_mode[PMC_SYNC_FLUSH] <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pending_head <= RST_ZERO;
		end else if (wr_hit(reg_wr_en, reg_addr, OFS_PENDING_HEAD)) begin
			pending_head <= {reg_wdata[31:3], 3'b000};
		end
	end

	// Software setting the valid bit wins over a hardware clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pending_head_valid <= 1'b0;
		end else if (wr_hit(reg_wr_en, reg_addr, OFS_PENDING_HEAD) && reg_wdata[0]) begin
			pending_head_valid <= 1'b1;
		end else if (wr_hit(reg_wr_en, reg_addr, OFS_PENDING_HEAD)) begin
			pending_head_valid <= 1'b0;
		end else if (pending_head_taken) begin
			pending_head_valid <= 1'b0;
		end else if (sw_mode[MODE_INVAL_PENDING] && heads_match) begin
			pending_head_valid <= 1'b0;
		end
	end

	// Timeout counter: zero write starts it, all-ones stops it
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			timeout_count <= RST_TIMEOUT_COUNT;
			timeout_hit <= 1'b0;
		end else begin
			timeout_hit <= 1'b0;
			if (wr_hit(reg_wr_en, reg_addr, OFS_TIMEOUT_COUNT)) begin
				timeout_count <= reg_wdata;
			end else if (timeout_count != COUNT_STOP) begin
				if (timeout_count == timeout_thresh) begin
					timeout_count <= RST_ZERO;
					timeout_hit <= 1'b1;
				end else begin
					timeout_count <= timeout_count + 32'h0000_0001;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			timeout_thresh <= RST_TIMEOUT_THRESH;
		end else if (wr_hit(reg_wr_en, reg_addr, OFS_TIMEOUT_THRESH)) begin
			timeout_thresh <= reg_wdata;
		end
	end

	// Sync flush sequence; flush only starts once the parser is idle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sync_state <= SYNC_IDLE;
			sync_done <= 1'b0;
		end else begin
			sync_done <= 1'b0;
			unique case (sync_state)
				SYNC_IDLE: begin
					if (parser_mode[PMC_SYNC_FLUSH] && parser_idle) begin
						sync_state <= SYNC_FLUSH;
					end
				end
				SYNC_FLUSH: begin
					if (engines_flushed) begin
						sync_done <= 1'b1;
						sync_state <= SYNC_WRITE;
					end
				end
				SYNC_WRITE: begin
					if (take_sync) begin
						sync_state <= SYNC_IDLE;
					end
				end
			endcase
		end
	end

	// Head report value is caught at the event; a new report reloads it
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			head_report_value <= RST_ZERO;
			head_report_pending <= 1'b0;
		end else begin
			if (parser_evt.report_head) begin
				head_report_value <= {head_addr[31:2], 2'b00};
				head_report_pending <= 1'b1;
			end else if (take_head) begin
				head_report_pending <= 1'b0;
			end
		end
	end

	// Status page writer; sync status has priority over head reports
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			status_wr <= '0;
		end else if (out_free) begin
			if (take_sync) begin
				status_wr.valid <= 1'b1;
				status_wr.addr <= {status_page[31:12], DW_SYNC_STATUS, 2'b00};
				// Toggle still in flight only when the write leaves at once
				status_wr.data <= interrupt_identity ^ {30'h0, sync_done, 1'b0};
				status_wr.flush_cache <= 1'b1;
			end else if (take_head) begin
				status_wr.valid <= 1'b1;
				status_wr.addr <= {status_page[31:12], DW_HEAD_REPORT, 2'b00};
				status_wr.data <= head_report_value;
				status_wr.flush_cache <= 1'b0;
			end else begin
				status_wr.valid <= 1'b0;
			end
		end
	end

	interrupt_identity_bank u_identity (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.timeout_hit(timeout_hit),
		.master_err_pending(master_err_pending),
		.sync_done(sync_done),
		.user_irq(parser_evt.user_irq),
		.clear_wr(wr_hit(reg_wr_en, reg_addr, OFS_IDENTITY)),
		.clear_data(reg_wdata),
		.identity(interrupt_identity)
	);

	// Read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = RST_ZERO;
		unique case (reg_addr)
			OFS_ERROR_LOCATION: next_rdata[LOC_BATCH] = error_from_batch;
			OFS_ERROR_HEADER: next_rdata = error_header;
			OFS_ACTIVE_HEAD: next_rdata = {head_addr[31:2], 2'b00};
			OFS_FETCH_OFFSET: next_rdata = {fetch_offset[31:3], 3'b000};
			OFS_STATUS_PAGE: next_rdata = status_page;
			OFS_NOOP_ID: next_rdata = {10'h000, noop_id};
			OFS_SW_MODE: begin
				next_rdata = {16'h0000, sw_mode};
				next_rdata[MODE_IDLE] = parser_idle;
			end
			OFS_IDENTITY: next_rdata = interrupt_identity;
			OFS_ERROR_STATUS: next_rdata[ERR_W-1:0] = error_status;
			OFS_ERROR_MASK: next_rdata[ERR_W-1:0] = error_mask;
			OFS_PARSER_MODE: next_rdata = {16'h0000, parser_mode};
			OFS_PENDING_HEAD: next_rdata = {pending_head[31:3], 2'b00, pending_head_valid};
			OFS_TIMEOUT_COUNT: next_rdata = timeout_count;
			OFS_TIMEOUT_THRESH: next_rdata = timeout_thresh;
			default: next_rdata = RST_ZERO;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata <= RST_ZERO;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata <= next_rdata;
			end
		end
	end
endmodule : cmd_streamer_status_regs

// [sim/cmd_streamer_status_regs_chk.sv]
// Port-level assertions for the streamer status registers
module cmd_streamer_status_regs_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reg_wr_en,
	input wire streamer_regs_pkg::reg_addr_t reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire streamer_regs_pkg::parser_event_t parser_evt,
	input wire logic stop_ring,
	input wire logic flush_req,
	input wire streamer_regs_pkg::status_write_t status_wr,
	input wire logic status_wr_ready,
	input wire logic [31:0] interrupt_identity
);
	timeunit 1ns;
	timeprecision 1ps;
	import streamer_regs_pkg::*;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	property p_user; parser_evt.user_irq && !reg_wr_en |-> ##[1:2] interrupt_identity[0]; endproperty
	a_user: assert property (p_user) else $error("user bit not set");
	property p_sync;
		$changed(interrupt_identity[1]) |-> $past(flush_req, 2) && !flush_req;
	endproperty
	a_sync: assert property (p_sync) else $error("sync bit moved outside flush");
	property p_flush; $fell(flush_req) |=> $changed(interrupt_identity[1]); endproperty
	a_flush: assert property (p_flush) else $error("flush ended without toggle");
	property p_sync_wr;
		$changed(interrupt_identity[1]) |-> ##[0:8] status_wr.valid && status_wr.flush_cache
			&& status_wr.addr[11:0] == 12'h000 && status_wr.data == interrupt_identity;
	endproperty
	a_sync_wr: assert property (p_sync_wr) else $error("sync status write wrong");
	property p_hold; status_wr.valid && !status_wr_ready |=> status_wr.valid && $stable(status_wr);
	endproperty
	a_hold: assert property (p_hold) else $error("status write dropped");
	property p_head;
		parser_evt.report_head |-> ##[1:6] status_wr.valid && status_wr.addr[11:0] == 12'h010;
	endproperty
	a_head: assert property (p_head) else $error("head report missing");
	property p_mask;
		$changed(stop_ring) |-> $past(reg_wr_en) && $past(reg_addr) == OFS_SW_MODE
			&& $past(reg_wdata[24]);
	endproperty
	a_mask: assert property (p_mask) else $error("mode bit changed unmasked");
	property p_stop;
		reg_wr_en && reg_addr == OFS_SW_MODE && reg_wdata[24] |=> stop_ring == $past(reg_wdata[8]);
	endproperty
	a_stop: assert property (p_stop) else $error("stop bit not taken");
	property p_master;
		$rose(interrupt_identity[2]) |-> $past(parser_evt.error_valid, 2)
			|| $past(parser_evt.page_fault, 2);
	endproperty
	a_master: assert property (p_master) else $error("master error without cause");
endmodule : cmd_streamer_status_regs_chk

bind cmd_streamer_status_regs cmd_streamer_status_regs_chk cmd_streamer_status_regs_chk_i (
	.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .parser_evt(parser_evt), .stop_ring(stop_ring),
	.flush_req(flush_req), .status_wr(status_wr), .status_wr_ready(status_wr_ready),
	.interrupt_identity(interrupt_identity));

// [sim/status_sink.sv]
// Memory sink for status dword writes, prompt or stalling
module status_sink (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire streamer_regs_pkg::status_write_t status_wr,
	output logic status_wr_ready,
	output logic acc,
	output logic [31:0] acc_addr,
	output logic [31:0] acc_data
);
	timeunit 1ns;
	timeprecision 1ps;
	import streamer_regs_pkg::*;
	logic [1:0] cnt;
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			cnt <= 2'h0;
		else
			cnt <= cnt + 2'h1;
	end
	// Slow mode takes one write in four cycles
	assign status_wr_ready = !slow || cnt == 2'h3;
	// Store area from dword 10h up is left to software
	always_ff @(posedge ref_clk) begin
		acc <= rst_n && status_wr.valid && status_wr_ready;
		acc_addr <= status_wr.addr;
		acc_data <= status_wr.data;
	end
endmodule : status_sink

// [sim/tb_cmd_streamer_status_regs.sv]
// Self-checking bench for the streamer status registers
module tb_cmd_streamer_status_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import streamer_regs_pkg::*;
	logic ref_clk = 0, rst_n = 0, reg_wr_en = 0, reg_rd_en = 0, parser_idle = 0;
	logic engines_flushed = 0, slow = 0, reg_rd_valid, stop_ring, flush_req, acc;
	logic pending_head_valid, status_wr_ready;
	reg_addr_t reg_addr = '0;
	logic [31:0] reg_wdata = '0, head_addr = '0, fetch_offset = '0, h;
	logic [31:0] reg_rdata, pending_head, interrupt_identity, acc_addr, acc_data;
	parser_event_t parser_evt = '0, e;
	status_write_t status_wr;
	logic [63:0] exp_q[$], wq[$];
	int err_total = 0, cmp_count = 0, i;
	reg_addr_t ro[5] = '{OFS_ERROR_LOCATION, OFS_ERROR_HEADER, OFS_ACTIVE_HEAD,
		OFS_FETCH_OFFSET, OFS_NOOP_ID};

	initial forever #12.5 ref_clk = ~ref_clk;

	cmd_streamer_status_regs cmd_streamer_status_regs_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
		.parser_evt(parser_evt), .head_addr(head_addr), .fetch_offset(fetch_offset),
		.parser_idle(parser_idle), .engines_flushed(engines_flushed),
		.pending_head_taken(1'b0), .stop_ring(stop_ring), .flush_req(flush_req),
		.pending_head(pending_head), .pending_head_valid(pending_head_valid),
		.status_wr(status_wr), .status_wr_ready(status_wr_ready),
		.interrupt_identity(interrupt_identity));
	status_sink status_sink_i (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
		.status_wr(status_wr), .status_wr_ready(status_wr_ready), .acc(acc),
		.acc_addr(acc_addr), .acc_data(acc_data));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task wrap_up;
		chk(exp_q.size() + wq.size(), 0);
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	task till(input logic ok);
		if (ok !== 1'b1) begin
			chk(ok, 1);
			wrap_up;
		end
	endtask : till

	task wr(input reg_addr_t a, input logic [31:0] d);
		@(negedge ref_clk);
		reg_wr_en = 1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_wr_en = 0;
	endtask : wr

	task rd(input reg_addr_t a, input logic [31:0] d);
		@(negedge ref_clk);
		reg_rd_en = 1;
		reg_addr = a;
		exp_q.push_back({32'h0, d});
		@(negedge ref_clk);
		reg_rd_en = 0;
	endtask : rd

	task pulse(input parser_event_t v);
		@(negedge ref_clk);
		parser_evt = v;
		@(negedge ref_clk);
		parser_evt = '0;
	endtask : pulse

	// Results land after the edge, so look at them half a cycle later
	always @(negedge ref_clk) begin
		if (reg_rd_valid)
			chk(reg_rdata, exp_q.pop_front());
		if (acc)
			chk({acc_addr, acc_data}, wq.pop_front());
	end

	initial begin
		#500000;
		$display("BAD %0t run limit hit", $time);
		err_total++;
		wrap_up;
	end

	initial begin
		void'($urandom(11));
		repeat (5) @(negedge ref_clk);
		rst_n = 1;
		rd(OFS_STATUS_PAGE, RST_STATUS_PAGE);
		rd(OFS_TIMEOUT_THRESH, RST_TIMEOUT_THRESH);
		rd(OFS_SW_MODE, 0);
		rd(16'h4000, 0);
		foreach (ro[i]) wr(ro[i], $urandom);
		foreach (ro[i]) rd(ro[i], 0);
		$display("reset and read-only test done");
		wr(OFS_ERROR_MASK, 1);
		e = '0;
		e.error_valid = 1;
		pulse(e);
		rd(OFS_ERROR_STATUS, 1);
		rd(OFS_IDENTITY, 0);
		wr(OFS_ERROR_STATUS, 1);
		wr(OFS_ERROR_MASK, 0);
		h = $urandom;
		e.exec_valid = 1;
		e.header = h;
		e.error_from_batch = 1;
		pulse(e);
		rd(OFS_ERROR_HEADER, h);
		rd(OFS_ERROR_LOCATION, 32'h8);
		rd(OFS_IDENTITY, 32'h4);
		wr(OFS_IDENTITY, 32'h4);
		rd(OFS_IDENTITY, 32'h4);
		wr(OFS_ERROR_STATUS, 1);
		wr(OFS_IDENTITY, 32'h4);
		rd(OFS_IDENTITY, 0);
		e.error_from_batch = 0;
		e.header = ~h;
		pulse(e);
		rd(OFS_ERROR_LOCATION, 0);
		rd(OFS_ERROR_HEADER, ~h);
		wr(OFS_ERROR_STATUS, 1);
		wr(OFS_IDENTITY, 32'h4);
		e = '0;
		e.page_fault = 1;
		pulse(e);
		rd(OFS_ERROR_STATUS, 2);
		rd(OFS_IDENTITY, 32'h4);
		wr(OFS_ERROR_STATUS, 2);
		wr(OFS_IDENTITY, 32'h4);
		rd(OFS_IDENTITY, 0);
		$display("parser error test done");
		e = '0;
		e.user_irq = 1;
		pulse(e);
		rd(OFS_IDENTITY, 1);
		wr(OFS_IDENTITY, 1);
		rd(OFS_IDENTITY, 0);
		e = '0;
		e.noop_update = 1;
		e.noop_id = $urandom;
		pulse(e);
		rd(OFS_NOOP_ID, {10'h0, e.noop_id});
		head_addr = $urandom;
		fetch_offset = $urandom;
		rd(OFS_ACTIVE_HEAD, head_addr & 32'hFFFF_FFFC);
		rd(OFS_FETCH_OFFSET, fetch_offset & 32'hFFFF_FFF8);
		$display("capture test done");
		wr(OFS_SW_MODE, 32'h0000_0100);
		rd(OFS_SW_MODE, 0);
		parser_idle = 1;
		wr(OFS_SW_MODE, 32'h0100_0100);
		rd(OFS_SW_MODE, 32'h0000_0300);
		chk(stop_ring, 1);
		wr(OFS_PARSER_MODE, 32'h0020_0020);
		for (i = 0; i < 20 && flush_req !== 1'b1; i++) @(negedge ref_clk);
		till(flush_req);
		repeat (4) @(negedge ref_clk);
		chk(interrupt_identity, 0);
		wq.push_back({RST_STATUS_PAGE, 32'h2});
		engines_flushed = 1;
		repeat (4) @(negedge ref_clk);
		chk(flush_req, 0);
		rd(OFS_PARSER_MODE, 0);
		engines_flushed = 0;
		wr(OFS_SW_MODE, 32'h0100_0000);
		chk(stop_ring, 0);
		$display("sync flush test done");
		wr(OFS_STATUS_PAGE, 32'hABCD_E123);
		rd(OFS_STATUS_PAGE, 32'hABCD_E000);
		slow = 1;
		head_addr = {h[31:2], 2'h0};
		wq.push_back({32'hABCD_E010, head_addr});
		e = '0;
		e.report_head = 1;
		pulse(e);
		for (i = 0; i < 40 && wq.size() > 0; i++) @(negedge ref_clk);
		till(wq.size() == 0);
		slow = 0;
		$display("head report test done");
		head_addr = ~h;
		wr(OFS_PENDING_HEAD, {h[31:3], 3'h1});
		wr(OFS_SW_MODE, 32'h0800_0800);
		chk(pending_head_valid, 1);
		head_addr = {h[31:3], 3'h0};
		for (i = 0; i < 10 && pending_head_valid !== 1'b0; i++) @(negedge ref_clk);
		till(pending_head_valid === 1'b0);
		chk(pending_head, {h[31:3], 3'h0});
		$display("pending head test done");
		wr(OFS_TIMEOUT_THRESH, 32'h5);
		wr(OFS_TIMEOUT_COUNT, 0);
		for (i = 0; i < 20 && interrupt_identity[7] !== 1'b1; i++) @(negedge ref_clk);
		till(interrupt_identity[7]);
		chk(i >= 4 && i <= 8, 1);
		wr(OFS_TIMEOUT_COUNT, COUNT_STOP);
		wr(OFS_IDENTITY, 32'h80);
		rd(OFS_IDENTITY, 32'h2);
		repeat (4) @(negedge ref_clk);
		$display("timeout test done");
		wrap_up;
	end
endmodule : tb_cmd_streamer_status_regs
